// ==== hw/pwm_channel_timer.sv ====
`timescale 1ns/1ps
// Overview of operation
// [R01] Each channel has counter, period, duty
// [R02] Output enables at once, waveform on tick
// [R03] Enable gated into channel at clock edge
// [R04] Start level sets initial output state
// [R05] Running channel buffers period and duty writes
// [R06] Stopped channel writes reach compare latches
// [R07] Count reads never disturb the channel
// [R08] Counter write clears, reloads, restarts output
// [R09] Disable freezes count, enable resumes it
// [R10] Stopped zero period clears counter on tick
// [R11] Counter write while running restarts period
// [R12] Alignment select picks left or centre
// [R13] Left mode counts up, wraps at period
// [R14] Centre mode turns down at period
// [R15] Centre mode reloads at zero, counts up
// [R16] Duty counts high or low time
// [R17] Frequency is clock over period or twice
// [R18] Software sets alignment before enabling
// [R19] Software writes counter before enabling
// [R20] Channels pick clock A or B pair
// [R21] Reset: counting up, disabled, stopped
// [R22] Counters run on bus clock with strobes
module pwm_channel_timer
   import pwm_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire clock_ticks_s ticks,
   input wire reg_req_s req,
   output logic [DATA_W-1:0] rdata,
   output logic [CHANNELS-1:0] pwm_out,
   output logic [CHANNELS-1:0] pwm_oe
);

   // Bank registers
   logic [CHANNELS-1:0] channel_run_enable; // Software run enables
   logic [CHANNELS-1:0] start_level_bank; // Output level at cycle start
   logic [CHANNELS-1:0] alignment_select_bank; // High for centre aligned
   logic [CHANNELS-1:0] scaled_clock_bank; // High picks the scaled clock
   logic [CHANNELS-1:0] run_sync; // Enable seen at a clock strobe

   // Per-channel double buffers and compare latches
   logic [7:0] period_value [CHANNELS];
   logic [7:0] duty_value [CHANNELS];
   logic [7:0] period_act [CHANNELS];
   logic [7:0] duty_act [CHANNELS];
   logic [7:0] channel_count [CHANNELS];

   // Core results
   logic [CHANNELS-1:0] core_wave;
   logic [CHANNELS-1:0] core_end;
   logic [CHANNELS-1:0] chan_tick;
   logic [CHANNELS-1:0] count_wr;
   logic [CHANNELS-1:0] period_wr;
   logic [CHANNELS-1:0] duty_wr;

   // Address decode
   logic [3:0] grp;
   logic [2:0] chan;
   logic chan_space;
   logic hit_run;
   logic hit_pol;
   logic hit_align;
   logic hit_clk;
   logic hit_count;
   logic hit_period;
   logic hit_duty;
   logic [DATA_W-1:0] read_value;
   logic [CHANNELS-1:0] next_pwm_out;

   assign grp = req.addr[7:4];
   assign chan = req.addr[2:0];
   // Bit 3 set in a channel group is a hole
   assign chan_space = !req.addr[3];
   assign hit_run = (req.addr == RUN_ENABLE_OFS);
   assign hit_pol = (req.addr == START_LEVEL_OFS);
   assign hit_align = (req.addr == ALIGN_OFS);
   assign hit_clk = (req.addr == CLOCK_SEL_OFS);
   assign hit_count = chan_space && (grp == COUNT_GRP);
   assign hit_period = chan_space && (grp == PERIOD_GRP);
   assign hit_duty = chan_space && (grp == DUTY_GRP);

   // Read selection; period and duty read back the buffers
   assign read_value = hit_run ? channel_run_enable
                     : hit_pol ? start_level_bank
                     : hit_align ? alignment_select_bank
                     : hit_clk ? scaled_clock_bank
                     : hit_count ? channel_count[chan] // see [R07]
                     : hit_period ? period_value[chan]
                     : hit_duty ? duty_value[chan]
                     : READ_IDLE;

   // Bank register writes
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         channel_run_enable <= BANK_RESET; // see [R21]
         start_level_bank <= BANK_RESET;
         alignment_select_bank <= BANK_RESET;
         scaled_clock_bank <= BANK_RESET;
      end
      else if (req.wr)
      begin
         // Mode bits are taken as written; changing them live may glitch
         if (hit_run)
            channel_run_enable <= req.wdata;
         if (hit_pol)
            start_level_bank <= req.wdata;
         if (hit_align)
            alignment_select_bank <= req.wdata; // see [R12] see [R18]
         if (hit_clk)
            scaled_clock_bank <= req.wdata;
      end
   end

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         rdata <= READ_IDLE;
      else if (req.rd)
         rdata <= read_value; // see [R07]
      else
         rdata <= READ_IDLE;
   end

   // Pin output: enable follows software at once, level follows the core
   assign next_pwm_out = channel_run_enable & (core_wave ^ start_level_bank); // see [R04] see [R16]

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pwm_out <= BANK_RESET;
         pwm_oe <= BANK_RESET;
      end
      else
      begin
         pwm_out <= next_pwm_out;
         pwm_oe <= channel_run_enable; // see [R02]
      end
   end

   for (genvar i = 0; i < CHANNELS; i++)
   begin : g_chan
      // Pair A serves channels 0,1,4,5; pair B serves 2,3,6,7
      localparam bit USES_B = ((i / 2) % 2) == 1;
      logic load_now;

      assign chan_tick[i] = USES_B
         ? (scaled_clock_bank[i] ? ticks.scaled_b : ticks.presc_b)
         : (scaled_clock_bank[i] ? ticks.scaled_a : ticks.presc_a); // see [R20]
      assign count_wr[i] = req.wr && hit_count && (chan == i);
      assign period_wr[i] = req.wr && hit_period && (chan == i);
      assign duty_wr[i] = req.wr && hit_duty && (chan == i);
      // Latches reload on period end, counter write or while stopped
      assign load_now = !channel_run_enable[i] || count_wr[i] || core_end[i]; // see [R05] see [R08]

      // Enable only reaches the counter on a strobe edge
      always_ff @(posedge ref_clk or negedge rstn)
      begin
         if (!rstn)
            run_sync[i] <= 1'b0;
         else if (chan_tick[i])
            run_sync[i] <= channel_run_enable[i]; // see [R02] see [R03]
      end

      // Double buffer and compare latches
      always_ff @(posedge ref_clk or negedge rstn)
      begin
         if (!rstn)
         begin
            period_value[i] <= PERIOD_RESET;
            duty_value[i] <= DUTY_RESET;
            period_act[i] <= PERIOD_RESET;
            duty_act[i] <= DUTY_RESET;
         end
         else
         begin
            if (period_wr[i])
               period_value[i] <= req.wdata;
            if (duty_wr[i])
               duty_value[i] <= req.wdata;
            // Stopped writes go straight through to the latch
            if (period_wr[i] && !channel_run_enable[i])
               period_act[i] <= req.wdata; // see [R06]
            else if (load_now)
               period_act[i] <= period_value[i]; // see [R05]
            if (duty_wr[i] && !channel_run_enable[i])
               duty_act[i] <= req.wdata; // see [R06]
            else if (load_now)
               duty_act[i] <= duty_value[i]; // see [R05]
         end
      end

      // One counter and compare core per channel
      pwm_counter_core u_core (
         .ref_clk(ref_clk),
         .rstn(rstn),
         .tick(chan_tick[i]),
         .running(run_sync[i]), // see [R09]
         .center_mode(alignment_select_bank[i]), // see [R17]
         .count_clear(count_wr[i]), // see [R11]
         .period_act(period_act[i]),
         .duty_act(duty_act[i]),
         .count(channel_count[i]),
         .dir(),
         .wave(core_wave[i]),
         .period_end(core_end[i])
      );

      AST_DIRECT_LOAD: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R06]
         period_wr[i] && !channel_run_enable[i] |=> period_act[i] == $past(req.wdata))
         else $error("stopped period write missed the latch");
      AST_HOLD_BUFFER: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R05]
         channel_run_enable[i] && !count_wr[i] && !core_end[i] |=> $stable(period_act[i]))
         else $error("running latch changed outside a period end");
      AST_ENABLE_SYNC: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R03]
         !chan_tick[i] |=> $stable(run_sync[i]))
         else $error("enable reached the counter off a strobe");
      AST_OE_IMMEDIATE: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R02]
         $rose(channel_run_enable[i]) |=> pwm_oe[i])
         else $error("output enable late after run enable");
      AST_START_LEVEL: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R08]
         count_wr[i] && channel_run_enable[i] ##1 channel_run_enable[i]
         && $stable(start_level_bank[i]) |=> pwm_out[i] == start_level_bank[i])
         else $error("counter write did not set the start level");
   end

   AST_READ_COUNT: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R07]
      req.rd && hit_count |=> rdata == $past(channel_count[chan]))
      else $error("count read returned a wrong value");
   AST_READ_IDLE: assert property (@(posedge ref_clk) disable iff (!rstn)
      !req.rd |=> rdata == READ_IDLE)
      else $error("read data stood beyond its cycle");

endmodule : pwm_channel_timer

// ==== hw/pwm_counter_core.sv ====
`timescale 1ns/1ps
module pwm_counter_core
   import pwm_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic running,
   input wire logic center_mode,
   input wire logic count_clear,
   input wire logic [7:0] period_act,
   input wire logic [7:0] duty_act,
   output logic [7:0] count,
   output count_dir_e dir,
   output logic wave,
   output logic period_end
);

   // Candidate counts
   logic [7:0] cnt_up;
   logic [7:0] cnt_dn;
   logic [7:0] step_val;
   logic period_zero;
   logic advance;
   logic left_wrap;
   logic center_top;
   logic center_bottom;
   logic zero_clear;

   assign cnt_up = count + CNT_STEP;
   assign cnt_dn = count - CNT_STEP;
   assign period_zero = (period_act == CNT_ZERO);
   // Counter only steps on a strobe while the synced enable is high
   assign advance = tick && running && !period_zero && !count_clear; // see [R03] see [R22]
   assign left_wrap = (cnt_up == period_act); // see [R13]
   assign center_top = (dir == DIR_UP) && (cnt_up == period_act); // see [R14]
   assign center_bottom = (dir == DIR_DOWN) && (cnt_dn == CNT_ZERO); // see [R15]
   // Zero period while stopped clears on the next selected strobe
   assign zero_clear = tick && !running && period_zero; // see [R10]

   // Next count by mode
   assign step_val = center_mode ? ((dir == DIR_DOWN) ? cnt_dn : cnt_up)
                   : (left_wrap ? CNT_ZERO : cnt_up); // see [R12]
   // End of effective period asks the owner to reload compare latches
   assign period_end = advance && (center_mode ? center_bottom : left_wrap); // see [R13] see [R15]

   // Counter, direction and output flip-flop
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count <= CNT_ZERO; // see [R21]
         dir <= DIR_UP;
         wave <= 1'b0;
      end
      else if (count_clear)
      begin
         // Any counter write restarts the cycle
         count <= CNT_ZERO; // see [R08] see [R11]
         dir <= DIR_UP;
         wave <= 1'b0;
      end
      else if (advance)
      begin
         count <= step_val;
         if (!center_mode || center_bottom)
            dir <= DIR_UP;
         else if (center_top)
            dir <= DIR_DOWN; // see [R14]
         // Period end resets the flop, duty match toggles it
         if (period_end)
            wave <= 1'b0;
         else if (step_val == duty_act)
            wave <= !wave; // see [R01] see [R04]
      end
      else if (zero_clear)
      begin
         count <= CNT_ZERO;
      end
   end

   AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R09]
      !running && !count_clear && !zero_clear |=> $stable(count) && $stable(wave))
      else $error("counter moved while channel stopped");
   AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R08]
      count_clear |=> count == CNT_ZERO && dir == DIR_UP && !wave)
      else $error("counter write did not restart the channel");
   AST_LEFT_WRAP: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R13]
      advance && !center_mode && cnt_up == period_act |=> count == CNT_ZERO && !wave)
      else $error("left aligned counter missed the period match");
   AST_LEFT_STEP: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R13]
      advance && !center_mode && cnt_up != period_act |=> count == $past(count) + CNT_STEP)
      else $error("left aligned counter did not count up");
   AST_CENTER_TOP: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R14]
      advance && center_mode && center_top ##1 (tick && running && !count_clear)
      |=> dir == DIR_DOWN && count == period_act - CNT_STEP)
      else $error("centre counter did not turn down at the period");
   AST_CENTER_BOTTOM: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R15]
      advance && center_mode && center_bottom |=> dir == DIR_UP && count == CNT_ZERO)
      else $error("centre counter did not turn up at zero");
   AST_ZERO_PERIOD: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R10]
      zero_clear && !count_clear |=> count == CNT_ZERO)
      else $error("zero period did not clear the stopped counter");
   AST_DUTY_TOGGLE: assert property (@(posedge ref_clk) disable iff (!rstn) // see [R04]
      advance && !period_end && step_val == duty_act |=> wave != $past(wave))
      else $error("duty match did not toggle the output");

endmodule : pwm_counter_core

// ==== hw/pwm_timer_pkg.sv ====
package pwm_timer_pkg;

   // Register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CHANNELS = 8;

   // Bank register offsets
   localparam logic [7:0] RUN_ENABLE_OFS = 8'h00;
   localparam logic [7:0] START_LEVEL_OFS = 8'h01;
   localparam logic [7:0] ALIGN_OFS = 8'h02;
   localparam logic [7:0] CLOCK_SEL_OFS = 8'h03;

   // Per-channel groups: group in addr[7:4], channel in addr[2:0]
   localparam logic [3:0] COUNT_GRP = 4'h1;
   localparam logic [3:0] PERIOD_GRP = 4'h2;
   localparam logic [3:0] DUTY_GRP = 4'h3;

   // Reset values and counter constants
   localparam logic [7:0] BANK_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'h00;
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_STEP = 8'h01;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // Counting direction
   typedef enum logic {
      DIR_UP = 1'b0,
      DIR_DOWN = 1'b1
   } count_dir_e;

   // Clock strobes from the prescaler and scalers, one bus cycle each
   typedef struct packed {
      logic presc_a;
      logic scaled_a;
      logic presc_b;
      logic scaled_b;
   } clock_ticks_s;

   // Software register request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

endpackage : pwm_timer_pkg

// ==== testbench/pwm_channel_timer_tb.sv ====
`timescale 1ns/1ps
module pwm_channel_timer_tb
   import pwm_timer_pkg::*;
;
   logic ref_clk; // Bus clock
   logic rstn; // Async reset
   clock_ticks_s ticks; // Channel clock strobes
   reg_req_s req; // Register request
   logic [DATA_W-1:0] rdata;
   logic [CHANNELS-1:0] pwm_out;
   logic [CHANNELS-1:0] pwm_oe;
   logic [15:0] period_cycles;
   logic [15:0] high_cycles;
   logic meas_valid;
   logic [2:0] wch; // Channel watched by the load
   wire pin_sel;
   logic armed; // Waveform notes are only taken once settled
   logic rd_d = 1'b0; // Read taken last edge
   int miscompares;
   int tests_run;
   int seed = 32'h47C8C45E;
   int cyc = 0; // Free cycle count for strobes
   logic [7:0] rd_q[$]; // Expected read data
   logic [31:0] wave_q[$]; // Expected period and high time
   logic [7:0] run; // Shadow of the bank registers
   logic [7:0] lvl;
   logic [7:0] algn;
   logic [7:0] csel;

   assign pin_sel = pwm_out[wch];

   pwm_channel_timer uut (.ref_clk(ref_clk), .rstn(rstn), .ticks(ticks), .req(req), .rdata(rdata),
      .pwm_out(pwm_out), .pwm_oe(pwm_oe));
   pwm_load load (.ref_clk(ref_clk), .rstn(rstn), .pin(pin_sel), .period_cycles(period_cycles),
      .high_cycles(high_cycles), .meas_valid(meas_valid));

   // Clock at 100 MHz
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Strobe rates: A every cycle, SA every 3, B every 2, SB every 4
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      ticks <= {1'b1, cyc % 3 == 0, cyc % 2 == 0, cyc % 4 == 0};
   end

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_byte

   task automatic cmp_wave(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_wave

   // Watcher: read data only in the cycle after the read, idle zero otherwise
   always @(posedge ref_clk)
   begin
      rd_d <= req.rd;
      if (rd_d === 1'b1)
         cmp_byte(rdata, rd_q.pop_front());
      else if (rstn === 1'b1)
         cmp_byte(rdata, READ_IDLE);
      if (armed === 1'b1 && meas_valid === 1'b1 && wave_q.size() > 0)
         cmp_wave({period_cycles, high_cycles}, wave_q.pop_front());
   end

   // One-cycle strobes; an edge passes between calls so no signal is set twice at once
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      rd_q.push_back(e);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
   endtask : reg_read

   // Bounded wait for a level on the channel 0 pin
   task automatic wait_pin(input logic v);
      for (int i = 0; i < 40 && pwm_out[0] !== v; i++)
      begin
         @(posedge ref_clk);
         #1;
      end
   endtask : wait_pin

   // Program one channel with random period and duty, then measure its waveform
   task automatic run_wave(input logic [2:0] ch);
      int p;
      int d;
      int r;
      int per;
      int hi;
      int i;
      p = 2 + {$random(seed)} % 8;
      d = 1 + {$random(seed)} % (p - 1);
      wch = ch;
      algn[ch] = ch[0];
      lvl[ch] = ch[1];
      csel[ch] = ch[2];
      reg_write(ALIGN_OFS, algn);
      reg_write(START_LEVEL_OFS, lvl);
      reg_write(CLOCK_SEL_OFS, csel);
      reg_write({PERIOD_GRP, 1'b0, ch}, 8'(p));
      reg_write({DUTY_GRP, 1'b0, ch}, 8'(d));
      reg_read({PERIOD_GRP, 1'b0, ch}, 8'(p));
      reg_write({COUNT_GRP, 1'b0, ch}, 8'hA5);
      reg_read({COUNT_GRP, 1'b0, ch}, CNT_ZERO);
      run[ch] = 1'b1;
      reg_write(RUN_ENABLE_OFS, run);
      @(posedge ref_clk);
      #1 cmp_byte(pwm_oe, run);
      r = ch[1] ? (ch[2] ? 4 : 2) : (ch[2] ? 3 : 1);
      per = (ch[0] ? 2 * p : p) * r;
      hi = (ch[1] ? d : p - d) * (ch[0] ? 2 : 1) * r;
      wave_q.push_back({16'(per), 16'(hi)});
      // Settle first: the cycle after enabling may be irregular
      repeat (3 * per + 4) @(posedge ref_clk);
      armed <= 1'b1;
      for (i = 0; i < 3 * per && wave_q.size() > 0; i++)
         @(posedge ref_clk);
      armed <= 1'b0;
      cmp_byte(8'(wave_q.size()), 8'h00);
      wave_q.delete();
      run[ch] = 1'b0;
      reg_write(RUN_ENABLE_OFS, run);
      repeat (2) @(posedge ref_clk);
      #1 cmp_byte(pwm_out, 8'h00);
   endtask : run_wave

   task automatic conclude();
      if (miscompares == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   // Watchdog well beyond the expected run of under 2000 cycles
   initial
   begin
      #400000;
      miscompares++;
      conclude();
   end

   // Main sequence
   initial
   begin
      rstn = 1'b0;
      req = '0;
      armed = 1'b0;
      wch = 3'h0;
      miscompares = 0;
      tests_run = 0;
      run = 8'h00;
      lvl = 8'h00;
      algn = 8'h00;
      csel = 8'h00;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      #1 cmp_byte(pwm_out | pwm_oe, 8'h00);
      reg_read(RUN_ENABLE_OFS, BANK_RESET);
      reg_read(START_LEVEL_OFS, BANK_RESET);
      reg_read(ALIGN_OFS, BANK_RESET);
      reg_read(CLOCK_SEL_OFS, BANK_RESET);
      reg_read(8'h17, CNT_ZERO);
      reg_read(8'h37, DUTY_RESET);
      // Unmapped place: bit 3 set must not alias channel 7
      reg_write(8'h2F, 8'hFF);
      reg_read(8'h2F, READ_IDLE);
      reg_read(8'h27, PERIOD_RESET);
      for (int c = 0; c < CHANNELS; c++)
         run_wave(3'(c));
      // Restart mid-period: long low phase, so only a restart brings the pin high
      wch = 3'h0;
      lvl = 8'h01;
      algn = 8'h00;
      csel = 8'h00;
      reg_write(START_LEVEL_OFS, lvl);
      reg_write(ALIGN_OFS, algn);
      reg_write(CLOCK_SEL_OFS, csel);
      reg_write(8'h20, 8'h10);
      reg_write(8'h30, 8'h05);
      reg_write(8'h10, 8'h00);
      run = 8'h01;
      reg_write(RUN_ENABLE_OFS, run);
      wait_pin(1'b1);
      wait_pin(1'b0);
      reg_write(8'h10, 8'h3C);
      repeat (2) @(posedge ref_clk);
      #1 cmp_byte({7'h00, pwm_out[0]}, 8'h01);
      // Stopped channel with zero period: count clears on the next strobe
      run = 8'h00;
      reg_write(RUN_ENABLE_OFS, run);
      reg_write(8'h20, 8'h00);
      repeat (3) @(posedge ref_clk);
      reg_read(8'h10, CNT_ZERO);
      repeat (3) @(posedge ref_clk);
      conclude();
   end
endmodule : pwm_channel_timer_tb

// ==== testbench/pwm_load.sv ====
`timescale 1ns/1ps
// Load on one output pin: measures rise-to-rise period and high time
module pwm_load
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic pin,
   output logic [15:0] period_cycles,
   output logic [15:0] high_cycles,
   output logic meas_valid
);
   logic prev; // Pin level one sample back
   logic [15:0] cnt; // Samples since the last rise
   logic [15:0] hcnt; // High samples since the last rise

   // Report on each rise; the first rise after reset reports the span counted from reset
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prev <= 1'b0;
         cnt <= 16'h0000;
         hcnt <= 16'h0000;
         period_cycles <= 16'h0000;
         high_cycles <= 16'h0000;
         meas_valid <= 1'b0;
      end
      else
      begin
         prev <= pin;
         meas_valid <= 1'b0;
         if (pin && !prev)
         begin
            period_cycles <= cnt;
            high_cycles <= hcnt;
            meas_valid <= (cnt != 16'h0000);
            cnt <= 16'h0001;
            hcnt <= 16'h0001;
         end
         else
         begin
            cnt <= cnt + 16'h0001;
            hcnt <= hcnt + {15'h0000, pin};
         end
      end
   end
endmodule : pwm_load
